// file: design/pmg_regs.sv
`timescale 1ns/10ps
`include "pmg_cfg.svh"

module pmg_regs (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire pmg_pkg::pmg_req_t avs_req,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [17:0]       periph_present,
    output pmg_pkg::pmg_gates_t    gate_off,
    output pmg_pkg::pmg_gates_t    periph_clk_en,
    output pmg_pkg::pmg_gates_t    periph_reg_wr_en
);
    localparam logic [15:0] MASKS [6] = '{`PMG_MASK_A, `PMG_MASK_B, `PMG_MASK_C,
                                          `PMG_MASK_F, `PMG_MASK_G, `PMG_MASK_H};

    pmg_pkg::pmg_word_t regs_reg [6];
    logic               ack_reg;
    logic [31:0]        rdata_reg;
    logic [17:0]        present_reg;
    logic [17:0]        present_meta_reg;
    logic               wait_reg;

    // Word index decode; anything beyond the last register is unmapped
    wire  [2:0]  word_idx = avs_req.address[4:2];
    wire         hit      = (avs_req.address[1:0] == 2'b00) && (word_idx < 3'd6);
    wire         access   = (avs_req.read || avs_req.write) && !ack_reg;
    // Write lands on the edge at which the master sees waitrequest low
    wire         wr_go    = ack_reg && avs_req.write && hit;
    wire  [15:0] lane_mask = {{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
    wire  [15:0] rd_word  = hit ? regs_reg[word_idx] : 16'h0000;

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_reg
            wire [15:0] wnext = (regs_reg[g] & ~lane_mask) | (avs_req.writedata[15:0] & lane_mask);
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    regs_reg[g] <= `PMG_RESET_VAL; // R14
                end else if (wr_go && (word_idx == 3'(g))) begin
                    regs_reg[g] <= wnext & MASKS[g]; // R10 R15
                end
            end
        end
    endgenerate

    // One wait state: request is answered on the second edge it is held
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg   <= 1'b0;
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= access;
            wait_reg  <= !access;
            rdata_reg <= {16'h0000, rd_word}; // R10
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;

    // Presence straps come from outside the clock domain: two flops before use
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            present_meta_reg <= 18'h0_0000;
            present_reg      <= 18'h0_0000;
        end else begin
            present_meta_reg <= periph_present;
            present_reg      <= present_meta_reg;
        end
    end

    wire [17:0] gate_bits = {
        regs_reg[0][`PMG_TMR3_BIT], regs_reg[0][`PMG_TMR2_BIT], regs_reg[0][`PMG_TMR1_BIT], // R3
        regs_reg[0][`PMG_PWMBLK_BIT],                                                       // R3
        regs_reg[0][`PMG_I2C_BIT], regs_reg[0][`PMG_UART_BIT], regs_reg[0][`PMG_SPI_BIT],   // R2
        regs_reg[0][`PMG_CONV_BIT],                                                         // R1
        regs_reg[1][`PMG_IC_BIT],                                                           // R4
        regs_reg[1][`PMG_OC_BIT],                                                           // R5
        regs_reg[2][`PMG_CMPBLK_BIT],                                                       // R6
        regs_reg[3][`PMG_PWM3_BIT], regs_reg[3][`PMG_PWM2_BIT], regs_reg[3][`PMG_PWM1_BIT], // R7
        regs_reg[4][`PMG_CMP2_BIT], regs_reg[4][`PMG_CMP1_BIT], regs_reg[4][`PMG_AMP1_BIT], // R8
        regs_reg[5][`PMG_AMP2_BIT]                                                          // R9
    };
    wire [17:0] run_next = ~gate_bits & present_reg; // R13

    // Outputs registered: gate change reaches peripherals one cycle later
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gate_off         <= '0;
            periph_clk_en    <= '0;
            periph_reg_wr_en <= '0;
        end else begin
            gate_off         <= gate_bits;  // R12
            periph_clk_en    <= run_next;   // R11 R12
            periph_reg_wr_en <= run_next;   // R11
        end
    end
endmodule : pmg_regs

// file: inc/pmg_cfg.svh
// How it works
// [R1] Register A bit 0 set turns the converter off; clear leaves it on.
// [R2] Register A bits 5, 3, 7 turn off async serial, SPI, I2C ports.
// [R3] Register A bits 13, 12, 11 gate timers three, two, one; bit 9 PWM block.
// [R4] Register B bit 8 set turns the capture unit off.
// [R5] Register B bit 0 set turns the compare unit off.
// [R6] Register C bit 10 set turns the comparator block off.
// [R7] Register F bits 10, 9, 8 turn off PWM generators three, two, one.
// [R8] Register G bits 9, 8, 1 turn off comparators two, one and amplifier one.
// [R9] Register H bit 10 set turns amplifier two off.
// [R10] Unassigned bits read zero and ignore writes.
// [R11] Gated peripheral loses clocks; its register writes are blocked.
// [R12] A gate change reaches the peripheral one cycle after the write.
// [R13] Peripheral runs only if present and its gate bit is clear.
// [R14] All gate bits clear at reset, so present peripherals start enabled; the enables reset low and rise on the third edge after reset release.
// [R15] Registers are plain 16-bit read/write words on the register bus.
`ifndef PMG_CFG_SVH
`define PMG_CFG_SVH

`define PMG_NUM_REGS    6
`define PMG_ADDR_W      5
`define PMG_OFF_A       5'h00
`define PMG_OFF_B       5'h04
`define PMG_OFF_C       5'h08
`define PMG_OFF_F       5'h0C
`define PMG_OFF_G       5'h10
`define PMG_OFF_H       5'h14
`define PMG_MASK_A      16'h3AA9
`define PMG_MASK_B      16'h0101
`define PMG_MASK_C      16'h0400
`define PMG_MASK_F      16'h0700
`define PMG_MASK_G      16'h0302
`define PMG_MASK_H      16'h0400
`define PMG_RESET_VAL   16'h0000
`define PMG_CONV_BIT    0
`define PMG_SPI_BIT     3
`define PMG_UART_BIT    5
`define PMG_I2C_BIT     7
`define PMG_PWMBLK_BIT  9
`define PMG_TMR1_BIT    11
`define PMG_TMR2_BIT    12
`define PMG_TMR3_BIT    13
`define PMG_OC_BIT      0
`define PMG_IC_BIT      8
`define PMG_CMPBLK_BIT  10
`define PMG_PWM1_BIT    8
`define PMG_PWM2_BIT    9
`define PMG_PWM3_BIT    10
`define PMG_AMP1_BIT    1
`define PMG_CMP1_BIT    8
`define PMG_CMP2_BIT    9
`define PMG_AMP2_BIT    10
`define PMG_NUM_PERIPH  18

`endif

// file: inc/pmg_pkg.sv
package pmg_pkg;
    typedef logic [15:0] pmg_word_t;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [4:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } pmg_req_t;

    typedef struct packed {
        logic        timer3_off;
        logic        timer2_off;
        logic        timer1_off;
        logic        pwm_block_off;
        logic        i2c_port_off;
        logic        async_serial_off;
        logic        spi_port_off;
        logic        converter_off;
        logic        capture_unit_off;
        logic        compare_unit_off;
        logic        comparator_block_off;
        logic        pwm_gen3_off;
        logic        pwm_gen2_off;
        logic        pwm_gen1_off;
        logic        comparator2_off;
        logic        comparator1_off;
        logic        amplifier1_off;
        logic        amplifier2_off;
    } pmg_gates_t;
endpackage : pmg_pkg

// file: tb/pmg_regs_asserts.sv
`timescale 1ns/10ps
module pmg_regs_asserts (
    input wire logic                sys_clk,
    input wire logic                rstn,
    input wire pmg_pkg::pmg_req_t   avs_req,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic [17:0]         periph_present,
    input wire pmg_pkg::pmg_gates_t gate_off,
    input wire pmg_pkg::pmg_gates_t periph_clk_en,
    input wire pmg_pkg::pmg_gates_t periph_reg_wr_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire done = !avs_waitrequest;
    a_wait_one: assert property ((avs_req.read | avs_req.write) && !done |=> done)
        else $error("request not answered after one wait state");
    a_wait_pulse: assert property (done |=> !done)
        else $error("waitrequest low for more than a cycle");
    a_read_top: assert property (done && avs_req.read |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read lanes not zero");
    a_unmapped_rd: assert property (done && avs_req.read && avs_req.address > 5'h14 |-> avs_readdata == '0)
        else $error("unmapped read not zero");
    a_en_pair: assert property (periph_clk_en == periph_reg_wr_en)
        else $error("clock and write enables differ");
    a_gated_off: assert property ((gate_off & periph_clk_en) == '0)
        else $error("gated peripheral still clocked");
    a_conv_bit: assert property (done && avs_req.write && avs_req.address == 5'h00 && avs_req.byteenable[0]
        |-> ##2 gate_off.converter_off == $past(avs_req.writedata[0], 2)) else $error("converter gate wrong");
    a_reset_gate: assert property ($rose(rstn) |-> gate_off == '0)
        else $error("gates not clear after reset");
endmodule : pmg_regs_asserts

// file: tb/pmg_regs_tb_top.sv
`timescale 1ns/10ps
module pmg_regs_tb_top;
    logic sys_clk = 0, rstn = 0;
    pmg_pkg::pmg_req_t req = '0;
    logic [31:0] rdata, r;
    logic wreq;
    logic [17:0] present = 18'h3_FFFF;
    pmg_pkg::pmg_gates_t goff, cken, wren;
    int err_total = 0, comparisons = 0;
    logic [4:0] ta[7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18};
    logic [15:0] te[7] = '{16'h3A_A9, 16'h01_01, 16'h04_00, 16'h07_00, 16'h03_02, 16'h04_00, 16'h00_00};
    pmg_regs u_pmg_regs (.sys_clk(sys_clk), .rstn(rstn), .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .periph_present(present), .gate_off(goff), .periph_clk_en(cken),
        .periph_reg_wr_en(wren));
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low, releases after that edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: {16'h0000, d}};
        do @(posedge sys_clk); while (wreq !== 1'b0);
        r = rdata;
        req <= '0;
    endtask : bus
    task automatic end_sim();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, ta[i], 16'hFFFF);
            bus(1'b0, ta[i], 16'h0000);
            chk(r, {16'h0000, te[i]});
        end
        $display("table test done");
        repeat (3) @(negedge sys_clk);
        chk(32'(goff), 32'h3_FFFF);
        chk(32'(cken), 32'h0);
        chk(32'(wren), 32'h0);
        bus(1'b1, 5'h00, 16'h0000);
        repeat (3) @(negedge sys_clk);
        chk(32'(cken.converter_off), 32'h1);
        $display("gate test done");
        @(posedge sys_clk);
        rstn <= 1'b0;
        present <= 18'h3_FFFE;
        @(posedge sys_clk);
        rstn <= 1'b1;
        @(negedge sys_clk);
        chk(32'(goff), 32'h0);
        bus(1'b0, 5'h00, 16'h0000);
        chk(r, 32'h0);
        repeat (3) @(negedge sys_clk);
        chk(32'(cken), 32'h3_FFFE);
        $display("reset test done");
        end_sim();
    end
    initial begin
        #20000;
        err_total++;
        end_sim();
    end
endmodule : pmg_regs_tb_top
bind pmg_regs pmg_regs_asserts u_pmg_regs_asserts (.sys_clk(sys_clk), .rstn(rstn), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .periph_present(periph_present),
    .gate_off(gate_off), .periph_clk_en(periph_clk_en), .periph_reg_wr_en(periph_reg_wr_en));
